// ### lpmc_ctrl.v
// low power mode controller with avalon-mm register slave
// Behaviour
// - after any reset the device sits in run mode, no low-power mode active.
// - sleep gates only the processor clock; any interrupt or event wakes it.
// - low-power run uses low-power regulator; processor clock capped at 2 MHz.
// - in low-power run, kernel clocks may come from fast internal rc.
// - low-power sleep entered only from low-power run; only processor clock gated.
// - wake from low-power sleep returns to low-power run, not run.
// - stop modes halt core clocks, pll and fast oscillators; ram kept.
// - slow crystal or slow internal rc keeps running in stop.
// - rtc optionally active in stop per configuration.
// - in stop a waking peripheral may request the fast internal rc.
// - three stop variants; stop 2 puts core domain into low leakage.
// - stop 0 keeps the main regulator on for fastest wakeup.
// - stop 1 keeps more wakeup sources than stop 2 and wakes faster.
// - stop exit clock is multi-speed rc or fast internal rc per software.
// - standby turns main regulator off, low-power regulator off unless retention, core domain and fast oscillators off.
// - rtc optionally active in standby per configuration.
// - brownout reset detector stays active in standby.
// - standby io state software selected: pull-up, pull-down or floating.
// - standby loses bank one ram and registers except backup domain.
// - with retention enabled, retainable ram kept in standby on low-power regulator.
// - standby exits on reset pin, watchdog, wakeup pin edge, rtc or css.
// - after standby wake the clock is multi-speed rc up to 8 MHz.
// - low-power regulator for lprun, lpsleep, stop1, stop2, standby with retention; main for run, sleep, stop0.
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.vh"

module lpmc_ctrl (
	input  wire        core_clk,
	input  wire        reset,
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	input  wire        sleep_request,
	input  wire        wake_irq_event,
	input  wire        wakeup_pin,
	input  wire        rtc_event,
	input  wire        watchdog_reset,
	input  wire        external_reset_pin,
	input  wire        clock_failure_detector,
	input  wire        periph_hsi_request,
	input  wire        stop2_periph_wake,
	output reg         cpu_clk_en,
	output reg         core_clk_en,
	output reg         cpu_clk_cap_2mhz,
	output reg         kernel_clk_fast_rc,
	output reg         main_regulator_en,
	output reg         low_power_regulator_en,
	output reg         core_supply_domain_on,
	output reg         core_low_leakage,
	output reg         pll_en,
	output reg         multi_speed_rc_osc_en,
	output reg         fast_internal_rc_osc_en,
	output reg         fast_crystal_osc_en,
	output reg         slow_crystal_osc_en,
	output reg         slow_internal_rc_osc_en,
	output reg         rtc_en,
	output reg         brownout_reset_detector_en,
	output reg         volatile_ram_bank_one_on,
	output reg         retainable_ram_bank_on,
	output reg  [1:0]  io_standby_state,
	output reg         io_standby_hold,
	output reg         sysclk_sel_fast_rc,
	output reg         msi_range_8mhz
);

////////////////////////////////////////////////////////////////////////////////
// states
localparam [7:0] ST_RUN     = 8'h01;
localparam [7:0] ST_SLEEP   = 8'h02;
localparam [7:0] ST_LPRUN   = 8'h04;
localparam [7:0] ST_LPSLEEP = 8'h08;
localparam [7:0] ST_STOP0   = 8'h10;
localparam [7:0] ST_STOP1   = 8'h20;
localparam [7:0] ST_STOP2   = 8'h40;
localparam [7:0] ST_STBY    = 8'h80;

reg [7:0]  state_reg;
reg [7:0]  state_next;
reg [31:0] ctrl_reg;
reg [31:0] cfg_reg;
reg [`LPMC_WK_W-1:0] wake_reg;
reg        wkpin_prev_reg;
reg        stby_exit_reg;
reg        stop_exit_reg;

wire [2:0] mode_sel = ctrl_reg[`LPMC_CTRL_MODE_MSB:`LPMC_CTRL_MODE_LSB];
wire       pin_edge = cfg_reg[`LPMC_CFG_WK_POL] ? (wkpin_prev_reg & ~wakeup_pin)
				: (~wkpin_prev_reg & wakeup_pin);
wire       in_stop  = |(state_reg & (ST_STOP0 | ST_STOP1 | ST_STOP2));
// stop 2 keeps fewer wakeup sources
wire       stop_wake = wake_irq_event | rtc_event | pin_edge | watchdog_reset
				| ((state_reg != ST_STOP2) & stop2_periph_wake);
wire       stby_wake = external_reset_pin | watchdog_reset | pin_edge
				| (cfg_reg[`LPMC_CFG_RTC_EN] & rtc_event)
				| clock_failure_detector;

////////////////////////////////////////////////////////////////////////////////
// bus slave: reads take one wait state so readdata stands when waitrequest drops
reg rd_ack_reg;
assign waitrequest = read & ~rd_ack_reg;
wire wr = write & ~waitrequest;

always @(posedge core_clk or posedge reset) begin
	if (reset) begin
		rd_ack_reg <= 1'b0;
		readdata   <= 32'h00000000;
	end else begin
		rd_ack_reg <= read & ~rd_ack_reg;
		if (read && !rd_ack_reg) begin
			case (address)
			`LPMC_OFS_CTRL:   readdata <= ctrl_reg;
			`LPMC_OFS_CFG:    readdata <= cfg_reg;
			`LPMC_OFS_STATUS: readdata <= {24'h000000, state_reg};
			`LPMC_OFS_WAKE:   readdata <= {26'h0000000, wake_reg};
			default:          readdata <= 32'h00000000;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// software registers; standby wipes non-backup registers
always @(posedge core_clk or posedge reset) begin
	if (reset) begin
		ctrl_reg <= `LPMC_CTRL_RESET;
		cfg_reg  <= `LPMC_CFG_RESET;
	end else if (stby_exit_reg) begin
		ctrl_reg <= `LPMC_CTRL_RESET;
	end else if (wr && address == `LPMC_OFS_CTRL) begin
		ctrl_reg <= {28'h0000000, writedata[3:0]};
	end else if (wr && address == `LPMC_OFS_CFG) begin
		cfg_reg <= {25'h0000000, writedata[6:0]};
	end
end

// wake cause flags, set wins over write-one-to-clear
wire [`LPMC_WK_W-1:0] wk_src = {wake_irq_event, external_reset_pin, clock_failure_detector,
				watchdog_reset, rtc_event, pin_edge};
wire                  wk_live    = (state_reg == ST_STBY) || in_stop;
wire                  wk_clr_sel = wr && (address == `LPMC_OFS_WAKE);
wire [`LPMC_WK_W-1:0] wake_next;

genvar gi;
generate
	for (gi = 0; gi < `LPMC_WK_W; gi = gi + 1) begin : g_wake
		assign wake_next[gi] = (wk_live & wk_src[gi]) | (wake_reg[gi] & ~(wk_clr_sel & writedata[gi]));
	end
endgenerate

always @(posedge core_clk or posedge reset) begin
	if (reset) begin
		wake_reg       <= {`LPMC_WK_W{1'b0}};
		wkpin_prev_reg <= 1'b0;
	end else begin
		wkpin_prev_reg <= wakeup_pin;
		wake_reg       <= wake_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// mode sequencer
always @* begin
	state_next = state_reg;
	case (state_reg)
	ST_RUN: begin
		if (ctrl_reg[`LPMC_CTRL_LPRUN])
			state_next = ST_LPRUN;
		else if (sleep_request) begin
			case (mode_sel)
			`LPMC_SEL_SLEEP:   state_next = ST_SLEEP;
			`LPMC_SEL_STOP0:   state_next = ST_STOP0;
			`LPMC_SEL_STOP1:   state_next = ST_STOP1;
			`LPMC_SEL_STOP2:   state_next = ST_STOP2;
			`LPMC_SEL_STANDBY: state_next = ST_STBY;
			default:           state_next = ST_SLEEP;
			endcase
		end
	end
	ST_SLEEP:
		if (wake_irq_event) state_next = ST_RUN;
	ST_LPRUN: begin
		if (!ctrl_reg[`LPMC_CTRL_LPRUN])
			state_next = ST_RUN;
		else if (sleep_request) begin
			case (mode_sel)
			`LPMC_SEL_SLEEP:   state_next = ST_LPSLEEP;
			`LPMC_SEL_STOP1:   state_next = ST_STOP1;
			`LPMC_SEL_STOP2:   state_next = ST_STOP2;
			`LPMC_SEL_STANDBY: state_next = ST_STBY;
			default:           state_next = ST_LPSLEEP;
			endcase
		end
	end
	ST_LPSLEEP:
		if (wake_irq_event) state_next = ST_LPRUN;
	ST_STOP0, ST_STOP1, ST_STOP2:
		if (stop_wake) state_next = ST_RUN;
	ST_STBY:
		if (stby_wake) state_next = ST_RUN;
	default: state_next = ST_RUN;
	endcase
end

always @(posedge core_clk or posedge reset) begin
	if (reset) begin
		state_reg     <= ST_RUN;
		stby_exit_reg <= 1'b0;
		stop_exit_reg <= 1'b0;
	end else begin
		state_reg     <= state_next;
		stby_exit_reg <= (state_reg == ST_STBY) && (state_next != ST_STBY);
		stop_exit_reg <= in_stop && (state_next == ST_RUN);
	end
end

////////////////////////////////////////////////////////////////////////////////
// power and clock outputs, registered
always @(posedge core_clk or posedge reset) begin
	if (reset) begin
		cpu_clk_en                 <= 1'b1;
		core_clk_en                <= 1'b1;
		cpu_clk_cap_2mhz           <= 1'b0;
		kernel_clk_fast_rc         <= 1'b0;
		main_regulator_en          <= 1'b1;
		low_power_regulator_en     <= 1'b0;
		core_supply_domain_on      <= 1'b1;
		core_low_leakage           <= 1'b0;
		pll_en                     <= 1'b1;
		multi_speed_rc_osc_en      <= 1'b1;
		fast_internal_rc_osc_en    <= 1'b1;
		fast_crystal_osc_en        <= 1'b1;
		slow_crystal_osc_en        <= 1'b0;
		slow_internal_rc_osc_en    <= 1'b1;
		rtc_en                     <= 1'b1;
		brownout_reset_detector_en <= 1'b1;
		volatile_ram_bank_one_on   <= 1'b1;
		retainable_ram_bank_on     <= 1'b1;
		io_standby_state           <= `LPMC_IO_FLOAT;
		io_standby_hold            <= 1'b0;
		sysclk_sel_fast_rc         <= 1'b0;
		msi_range_8mhz             <= 1'b0;
	end else begin
		cpu_clk_en  <= state_next == ST_RUN || state_next == ST_LPRUN;
		core_clk_en <= state_next != ST_STOP0 && state_next != ST_STOP1
			&& state_next != ST_STOP2 && state_next != ST_STBY;
		cpu_clk_cap_2mhz   <= state_next == ST_LPRUN || state_next == ST_LPSLEEP;
		kernel_clk_fast_rc <= state_next == ST_LPRUN || state_next == ST_LPSLEEP;
		main_regulator_en  <= state_next == ST_RUN || state_next == ST_SLEEP
			|| state_next == ST_STOP0;
		low_power_regulator_en <= state_next == ST_LPRUN || state_next == ST_LPSLEEP
			|| state_next == ST_STOP1 || state_next == ST_STOP2
			|| (state_next == ST_STBY && cfg_reg[`LPMC_CFG_RAM_RET]);
		core_supply_domain_on  <= state_next != ST_STBY;
		core_low_leakage       <= state_next == ST_STOP2;
		pll_en                 <= core_clk_next_on(state_next) && state_next != ST_LPRUN
			&& state_next != ST_LPSLEEP;
		multi_speed_rc_osc_en   <= core_clk_next_on(state_next);
		fast_internal_rc_osc_en <= core_clk_next_on(state_next)
			|| (state_next != ST_STBY && periph_hsi_request);
		fast_crystal_osc_en     <= core_clk_next_on(state_next);
		slow_crystal_osc_en     <= cfg_reg[`LPMC_CFG_SLOW_XTAL];
		slow_internal_rc_osc_en <= ~cfg_reg[`LPMC_CFG_SLOW_XTAL];
		rtc_en <= core_clk_next_on(state_next) || cfg_reg[`LPMC_CFG_RTC_EN];
		brownout_reset_detector_en <= 1'b1;
		volatile_ram_bank_one_on   <= state_next != ST_STBY;
		retainable_ram_bank_on     <= state_next != ST_STBY || cfg_reg[`LPMC_CFG_RAM_RET];
		io_standby_state <= cfg_reg[`LPMC_CFG_IO_MSB:`LPMC_CFG_IO_LSB];
		io_standby_hold  <= state_next == ST_STBY;
		if (stby_exit_reg) begin
			sysclk_sel_fast_rc <= 1'b0;
			msi_range_8mhz     <= 1'b1;
		end else if (stop_exit_reg) begin
			sysclk_sel_fast_rc <= cfg_reg[`LPMC_CFG_STOP_FAST];
			msi_range_8mhz     <= 1'b0;
		end
	end
end

function core_clk_next_on;
	input [7:0] st;
	begin
		core_clk_next_on = ~|(st & (ST_STOP0 | ST_STOP1 | ST_STOP2 | ST_STBY));
	end
endfunction

endmodule
`default_nettype wire

// ### lpmc_consts.vh
// constants for the low power mode controller
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH

// register byte offsets
`define LPMC_OFS_CTRL       4'h0
`define LPMC_OFS_CFG        4'h4
`define LPMC_OFS_STATUS     4'h8
`define LPMC_OFS_WAKE       4'hc

// ctrl fields
`define LPMC_CTRL_MODE_LSB  0
`define LPMC_CTRL_MODE_MSB  2
`define LPMC_CTRL_LPRUN     3
`define LPMC_CTRL_RESET     32'h00000000

// mode select codes
`define LPMC_SEL_SLEEP      3'h0
`define LPMC_SEL_STOP0      3'h1
`define LPMC_SEL_STOP1      3'h2
`define LPMC_SEL_STOP2      3'h3
`define LPMC_SEL_STANDBY    3'h4

// cfg fields
`define LPMC_CFG_RTC_EN     0
`define LPMC_CFG_STOP_FAST  1
`define LPMC_CFG_RAM_RET    2
`define LPMC_CFG_SLOW_XTAL  3
`define LPMC_CFG_WK_POL     4
`define LPMC_CFG_IO_LSB     5
`define LPMC_CFG_IO_MSB     6
`define LPMC_CFG_RESET      32'h00000001

// io standby states
`define LPMC_IO_FLOAT       2'h0
`define LPMC_IO_PULLUP      2'h1
`define LPMC_IO_PULLDOWN    2'h2

// wake cause bits
`define LPMC_WK_PIN         0
`define LPMC_WK_RTC         1
`define LPMC_WK_WDOG        2
`define LPMC_WK_CSS         3
`define LPMC_WK_RSTPIN      4
`define LPMC_WK_IRQ         5
`define LPMC_WK_W           6

// clock limits in hz
`define LPMC_LPRUN_MAX_HZ   2000000
`define LPMC_STOP_MSI_HZ    48000000
`define LPMC_STBY_MSI_HZ    8000000

`endif

// ### lpmc_ctrl_chk.sv
// assertions for the low power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sleep_request,
	input wire logic wake_irq_event,
	input wire logic cpu_clk_en,
	input wire logic core_clk_en,
	input wire logic cpu_clk_cap_2mhz,
	input wire logic main_regulator_en,
	input wire logic low_power_regulator_en,
	input wire logic core_supply_domain_on,
	input wire logic core_low_leakage,
	input wire logic pll_en,
	input wire logic fast_crystal_osc_en,
	input wire logic fast_internal_rc_osc_en,
	input wire logic slow_crystal_osc_en,
	input wire logic slow_internal_rc_osc_en,
	input wire logic brownout_reset_detector_en,
	input wire logic volatile_ram_bank_one_on,
	input wire logic msi_range_8mhz
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	a_lprun_regulator: assert property (cpu_clk_cap_2mhz |-> low_power_regulator_en && !main_regulator_en)
		else $error("lprun regulator wrong");
	a_stop_osc_off: assert property (!core_clk_en |-> !pll_en && !fast_crystal_osc_en)
		else $error("fast oscillator on in stop");
	a_stop_ram_kept: assert property (!core_clk_en && core_supply_domain_on |-> volatile_ram_bank_one_on)
		else $error("ram lost in stop");
	a_slow_osc_alive: assert property (!core_clk_en |-> slow_crystal_osc_en || slow_internal_rc_osc_en)
		else $error("slow oscillator off");
	a_stop2_leakage: assert property (core_low_leakage |-> !core_clk_en && low_power_regulator_en)
		else $error("low leakage outside stop 2");
	a_standby_power: assert property (!core_supply_domain_on |-> !main_regulator_en && !fast_internal_rc_osc_en
		&& !volatile_ram_bank_one_on && brownout_reset_detector_en)
		else $error("standby power state wrong");
	a_entry_on_request: assert property ($fell(cpu_clk_en) |-> $past(sleep_request))
		else $error("mode entered without request");
	a_lpsleep_return: assert property (!cpu_clk_en && core_clk_en && low_power_regulator_en && wake_irq_event
		|=> cpu_clk_en && low_power_regulator_en)
		else $error("lpsleep wake not to lprun");
	a_standby_wake_clk: assert property ($rose(core_supply_domain_on) |-> ##[0:2] msi_range_8mhz)
		else $error("standby wake clock wrong");
	c_standby: cover property (!core_supply_domain_on);
	c_stop2: cover property (core_low_leakage);
	c_lpsleep: cover property (cpu_clk_cap_2mhz && !cpu_clk_en);
endmodule
////////////////////////////////////////////////////////////////
bind lpmc_ctrl lpmc_chk u_chk (.*);
`default_nettype wire

// ### lpmc_ctrl_tb.sv
// bench for the low power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.vh"
module lpmc_ctrl_tb;
	logic        core_clk, reset, read, write, sleep_request, periph_hsi_request, stop2_periph_wake;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, q, cfg;
	logic        waitrequest, cpu_clk_en, core_clk_en, cpu_clk_cap_2mhz, kernel_clk_fast_rc, main_regulator_en;
	logic        low_power_regulator_en, core_supply_domain_on, core_low_leakage, pll_en, multi_speed_rc_osc_en;
	logic        fast_internal_rc_osc_en, fast_crystal_osc_en, slow_crystal_osc_en, slow_internal_rc_osc_en, rtc_en;
	logic        brownout_reset_detector_en, volatile_ram_bank_one_on, retainable_ram_bank_on, io_standby_hold;
	logic        sysclk_sel_fast_rc, msi_range_8mhz;
	logic [1:0]  io_standby_state;
	logic [5:0]  wk;
	logic [15:0] lf = 16'h2870;
	int          n_errors = 0, tests_run = 0, m;
	wire         wakeup_pin = wk[0], rtc_event = wk[1], watchdog_reset = wk[2];
	wire         clock_failure_detector = wk[3], external_reset_pin = wk[4], wake_irq_event = wk[5];
	lpmc_ctrl dut (
		.core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .sleep_request(sleep_request),
		.wake_irq_event(wake_irq_event), .wakeup_pin(wakeup_pin), .rtc_event(rtc_event),
		.watchdog_reset(watchdog_reset), .external_reset_pin(external_reset_pin),
		.clock_failure_detector(clock_failure_detector), .periph_hsi_request(periph_hsi_request),
		.stop2_periph_wake(stop2_periph_wake), .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en),
		.cpu_clk_cap_2mhz(cpu_clk_cap_2mhz), .kernel_clk_fast_rc(kernel_clk_fast_rc),
		.main_regulator_en(main_regulator_en), .low_power_regulator_en(low_power_regulator_en),
		.core_supply_domain_on(core_supply_domain_on), .core_low_leakage(core_low_leakage), .pll_en(pll_en),
		.multi_speed_rc_osc_en(multi_speed_rc_osc_en), .fast_internal_rc_osc_en(fast_internal_rc_osc_en),
		.fast_crystal_osc_en(fast_crystal_osc_en), .slow_crystal_osc_en(slow_crystal_osc_en),
		.slow_internal_rc_osc_en(slow_internal_rc_osc_en), .rtc_en(rtc_en),
		.brownout_reset_detector_en(brownout_reset_detector_en),
		.volatile_ram_bank_one_on(volatile_ram_bank_one_on), .retainable_ram_bank_on(retainable_ram_bank_on),
		.io_standby_state(io_standby_state), .io_standby_hold(io_standby_hold),
		.sysclk_sel_fast_rc(sysclk_sel_fast_rc), .msi_range_8mhz(msi_range_8mhz)
	);
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task hang;
		n_errors++;
		final_report();
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int i;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (waitrequest !== 1'b0 && i < 50);
		r = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (i >= 50) hang();
	endtask
	task rd(input string nm, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	task enter;
		@(posedge core_clk) sleep_request <= 1'b1;
		@(posedge core_clk) sleep_request <= 1'b0;
		#1;
	endtask
	task wake(input int k);
		int i;
		@(posedge core_clk) wk[k] <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (cpu_clk_en !== 1'b1 && i < 20);
		wk[k] <= 1'b0;
		if (i >= 20) hang();
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#5000000;
		hang();
	end
	initial begin
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		sleep_request = 1'b0;
		periph_hsi_request = 1'b0;
		stop2_periph_wake = 1'b0;
		wk = 6'h0;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		#1 chk("cpu clk", 32'h1, cpu_clk_en);
		rd("status", `LPMC_OFS_STATUS, 32'h1);
		rd("cfg", `LPMC_OFS_CFG, `LPMC_CFG_RESET);
		rd("unmapped", 4'h2, 32'h0);
		bus(1'b1, `LPMC_OFS_CTRL, 32'h2, q);
		rd("no entry", `LPMC_OFS_STATUS, 32'h1);
		$display("test done: reset");
		bus(1'b1, `LPMC_OFS_CTRL, 32'h0, q);
		enter();
		chk("sleep cpu", 32'h0, cpu_clk_en);
		chk("sleep core", 32'h1, core_clk_en);
		rd("sleep", `LPMC_OFS_STATUS, 32'h2);
		wake(5);
		rd("sleep exit", `LPMC_OFS_STATUS, 32'h1);
		$display("test done: sleep");
		bus(1'b1, `LPMC_OFS_CTRL, 32'h8, q);
		rd("lprun", `LPMC_OFS_STATUS, 32'h4);
		chk("cap", 32'h1, cpu_clk_cap_2mhz);
		chk("main reg", 32'h0, main_regulator_en);
		chk("kernel", 32'h1, kernel_clk_fast_rc);
		enter();
		rd("lpsleep", `LPMC_OFS_STATUS, 32'h8);
		wake(5);
		rd("lpsleep exit", `LPMC_OFS_STATUS, 32'h4);
		bus(1'b1, `LPMC_OFS_CTRL, 32'h0, q);
		rd("run", `LPMC_OFS_STATUS, 32'h1);
		$display("test done: lprun");
		for (m = 1; m < 4; m++) begin
			lf = lfsr(lf);
			cfg = {30'h0, lf[1:0]};
			bus(1'b1, `LPMC_OFS_CFG, cfg, q);
			bus(1'b1, `LPMC_OFS_CTRL, 32'(m), q);
			enter();
			chk("stop clk", 32'h0, core_clk_en);
			chk("pll", 32'h0, pll_en);
			chk("slow osc", 32'h1, slow_crystal_osc_en | slow_internal_rc_osc_en);
			chk("rtc", 32'(lf[0]), rtc_en);
			chk("leak", 32'(m == 3), core_low_leakage);
			chk("main", 32'(m == 1), main_regulator_en);
			@(posedge core_clk) periph_hsi_request <= 1'b1;
			@(posedge core_clk) periph_hsi_request <= 1'b0;
			#1 chk("hsi", 32'h1, fast_internal_rc_osc_en);
			if (m == 3) begin
				@(posedge core_clk) stop2_periph_wake <= 1'b1;
				repeat (2) @(posedge core_clk);
				stop2_periph_wake <= 1'b0;
			end
			rd("stop", `LPMC_OFS_STATUS, 32'h8 << m);
			wake(m == 1 ? 5 : m == 2 ? 2 : 0);
			chk("exit clk", 32'(lf[1]), sysclk_sel_fast_rc);
			rd("stop exit", `LPMC_OFS_STATUS, 32'h1);
			rd("wake cause", `LPMC_OFS_WAKE, 32'h1 << (m == 1 ? 5 : m == 2 ? 2 : 0));
			bus(1'b1, `LPMC_OFS_WAKE, 32'h3f, q);
			rd("wake clear", `LPMC_OFS_WAKE, 32'h0);
		end
		$display("test done: stop");
		for (m = 0; m < 5; m++) begin
			lf = lfsr(lf);
			cfg = {25'h0, lf[3:2] % 2'h3, 2'b00, lf[4], 2'b11};
			bus(1'b1, `LPMC_OFS_CFG, cfg, q);
			bus(1'b1, `LPMC_OFS_CTRL, 32'h4, q);
			enter();
			chk("core", 32'h0, core_supply_domain_on);
			chk("msi", 32'h0, multi_speed_rc_osc_en);
			chk("rtc", 32'h1, rtc_en);
			chk("bor", 32'h1, brownout_reset_detector_en);
			chk("io", 32'(cfg[6:5]), io_standby_state);
			chk("ram1", 32'h0, volatile_ram_bank_one_on);
			chk("ram2", 32'(lf[4]), retainable_ram_bank_on);
			chk("lp reg", 32'(lf[4]), low_power_regulator_en);
			wake(m);
			chk("msi8", 32'h1, msi_range_8mhz);
			chk("sysclk", 32'h0, sysclk_sel_fast_rc);
			rd("ctrl", `LPMC_OFS_CTRL, 32'h0);
			rd("stby exit", `LPMC_OFS_STATUS, 32'h1);
		end
		$display("test done: standby");
		bus(1'b1, `LPMC_OFS_CTRL, 32'h8, q);
		@(posedge core_clk) reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		#1 chk("reset cap", 32'h0, cpu_clk_cap_2mhz);
		rd("reset status", `LPMC_OFS_STATUS, 32'h1);
		rd("reset cfg", `LPMC_OFS_CFG, `LPMC_CFG_RESET);
		$display("test done: reset again");
		final_report();
	end
endmodule
`default_nettype wire
